// >>> verilog/fwc_device.sv
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: 2 KB erase pages, 32-bit program words
// RULE2: 15-bit word address from high:low registers
// RULE3: programming only clears bits
// RULE4: erased bits read back as one
// RULE5: single word or consecutive block from start
// RULE6: writing write bit starts, address latched
// RULE7: word busy high while word programs
// RULE8: first byte is LSB, commit per four
// RULE9: writer software runs from RAM range
// RULE10: starting a write never stalls the writer
// RULE11: flash access while word busy is violation
// RULE12: trigger pulses whenever data port ready
// RULE13: DMA uses single byte transfers, multiple-four
// RULE14: stall over 40 us abandons word, clears write
// RULE15: setting write bit yields first trigger
// RULE16: word programming lasts 20 us
// RULE17: page erase 20 ms, page from high[6:1]
// RULE18: timeout after busy falls drops busy
// RULE19: timing value resets to 0x2A
// RULE20: address increments, counter clears per word
// RULE21: byte counter clears on start or abort
module fwc_device #(
   parameter int ERASE_CYC = fwc_pkg::PAGE_ERASE_CYC,
   parameter int PROG_CYC  = fwc_pkg::WORD_PROG_CYC,
   parameter int STALL_CYC = fwc_pkg::STALL_CYC
) (
   input  wire logic pclk,
   input  wire logic presetn,
   fwc_if.dev        bus
);
   localparam int AW = fwc_pkg::WORD_ADDR_W;

   typedef struct packed {
      fwc_pkg::fwc_state_t st;
      logic                wr_bit;
      logic [AW-1:0]       addr;
      logic [7:0]          addr_hi;
      logic [7:0]          addr_lo;
      logic [5:0]          timing;
      logic [31:0]         word;
      logic [1:0]          cnt;
      logic [31:0]         timer;
      logic                dma_trigger_select;
      logic                busy;
      logic                word_busy;
      logic [7:0]          rdata;
      logic                rvalid;
      logic                viol;
   } fwc_dev_t;

   fwc_dev_t s_q;
   fwc_dev_t s_d;
   logic     prog_en;
   logic     erase_en;
   logic     rd_en;
   logic     ctl_wr;
   logic     data_wr;

   assign ctl_wr  = bus.reg_wr && (bus.reg_sel == fwc_pkg::SEL_CTL);
   assign data_wr = bus.reg_wr && (bus.reg_sel == fwc_pkg::SEL_DATA);

   always_comb
   begin
      s_d      = s_q;
      prog_en  = 1'b0;
      erase_en = 1'b0;
      rd_en    = 1'b0;
      s_d.dma_trigger_select   = 1'b0;
      s_d.rvalid = 1'b0;
      s_d.viol   = 1'b0;
      if (bus.reg_wr)
      begin
         case (bus.reg_sel)
            fwc_pkg::SEL_ADDR_LO: s_d.addr_lo = bus.reg_wdata;
            fwc_pkg::SEL_ADDR_HI: s_d.addr_hi = bus.reg_wdata;
            fwc_pkg::SEL_TIMING:  s_d.timing  = bus.reg_wdata[5:0];
            default: ;
         endcase
      end
      case (s_q.st)
         fwc_pkg::ST_IDLE:
         begin
            // the writer is never held off; the start is a single write
            if (ctl_wr) // [RULE10]
            begin
               s_d.cnt   = 2'h0; // [RULE21]
               s_d.timer = 32'h0;
               s_d.addr  = {s_q.addr_hi[6:0], s_q.addr_lo}; // [RULE2] [RULE6]
               s_d.wr_bit = bus.reg_wdata[fwc_pkg::CTL_WRITE];
               if (bus.reg_wdata[fwc_pkg::CTL_ERASE])
               begin
                  s_d.st = fwc_pkg::ST_ERASE;
               end
               else if (bus.reg_wdata[fwc_pkg::CTL_WRITE])
               begin
                  s_d.st   = fwc_pkg::ST_COLLECT; // [RULE5]
                  s_d.dma_trigger_select = 1'b1; // [RULE15]
               end
            end
         end
         fwc_pkg::ST_ERASE:
         begin
            s_d.timer = s_q.timer + 32'h1;
            if (s_q.timer == 32'(ERASE_CYC - 1)) // [RULE17]
            begin
               erase_en  = 1'b1;
               s_d.timer = 32'h0;
               // erase then write when both bits were set together
               if (s_q.wr_bit)
               begin
                  s_d.st   = fwc_pkg::ST_COLLECT;
                  s_d.dma_trigger_select = 1'b1; // [RULE15]
               end
               else
               begin
                  s_d.st = fwc_pkg::ST_IDLE;
               end
            end
         end
         fwc_pkg::ST_COLLECT:
         begin
            s_d.timer = s_q.timer + 32'h1;
            if (ctl_wr && !bus.reg_wdata[fwc_pkg::CTL_WRITE])
            begin
               s_d.st     = fwc_pkg::ST_IDLE;
               s_d.wr_bit = 1'b0;
               s_d.cnt    = 2'h0; // [RULE21]
            end
            else if (data_wr)
            begin
               s_d.word[{s_q.cnt, 3'b000} +: 8] = bus.reg_wdata; // [RULE8]
               s_d.timer = 32'h0;
               if (s_q.cnt == 2'h3)
               begin
                  s_d.st  = fwc_pkg::ST_PROGRAM; // [RULE8]
                  s_d.cnt = 2'h0;
               end
               else
               begin
                  s_d.cnt  = s_q.cnt + 2'h1;
                  s_d.dma_trigger_select = 1'b1; // [RULE12]
               end
            end
            else if (s_q.timer >= 32'(STALL_CYC)) // [RULE14] [RULE18]
            begin
               // partial word is dropped; software must restart it
               s_d.st     = fwc_pkg::ST_IDLE;
               s_d.wr_bit = 1'b0;
               s_d.cnt    = 2'h0; // [RULE21]
            end
         end
         fwc_pkg::ST_PROGRAM:
         begin
            s_d.timer = s_q.timer + 32'h1;
            if (s_q.timer == 32'(PROG_CYC - 1)) // [RULE16]
            begin
               prog_en   = 1'b1;
               s_d.timer = 32'h0;
               s_d.addr  = s_q.addr + AW'(1); // [RULE20]
               s_d.st    = fwc_pkg::ST_COLLECT;
               s_d.dma_trigger_select  = 1'b1; // [RULE12]
            end
         end
         default: s_d.st = fwc_pkg::ST_IDLE;
      endcase
      s_d.busy      = (s_d.st != fwc_pkg::ST_IDLE); // [RULE18]
      s_d.word_busy = (s_d.st == fwc_pkg::ST_PROGRAM); // [RULE7]
      if (bus.reg_rd)
      begin
         s_d.rvalid = 1'b1;
         case (bus.reg_sel)
            fwc_pkg::SEL_CTL:
               s_d.rdata = {s_q.busy, s_q.word_busy, 4'h0, s_q.wr_bit,
                            s_q.st == fwc_pkg::ST_ERASE};
            fwc_pkg::SEL_ADDR_LO: s_d.rdata = s_q.addr_lo;
            fwc_pkg::SEL_ADDR_HI: s_d.rdata = s_q.addr_hi;
            fwc_pkg::SEL_TIMING:  s_d.rdata = {2'h0, s_q.timing};
            default:              s_d.rdata = 8'h00;
         endcase
      end
      if (bus.rd_req)
      begin
         // erase also blocks the array, so it is flagged the same way
         if (s_q.word_busy || s_q.st == fwc_pkg::ST_ERASE)
         begin
            s_d.viol = 1'b1; // [RULE11]
         end
         else
         begin
            rd_en = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q        <= '0;
         s_q.st     <= fwc_pkg::ST_IDLE;
         s_q.timing <= fwc_pkg::TIMING_RST; // [RULE19]
      end
      else
      begin
         s_q <= s_d;
      end
   end

   fwc_array #(
      .ADDR_W   (AW),
      .PAGE_LSB (fwc_pkg::PAGE_LSB)
   ) u_array (
      .pclk       (pclk),
      .presetn    (presetn),
      .prog_en    (prog_en),
      .prog_addr  (s_q.addr),
      .prog_data  (s_q.word),
      .erase_en   (erase_en),
      .erase_page (s_q.addr_hi[fwc_pkg::PAGE_SEL_LSB +:
                               fwc_pkg::PAGE_SEL_W]), // [RULE17]
      .rd_en      (rd_en),
      .rd_addr    (bus.rd_addr),
      .rd_valid   (bus.rd_valid),
      .rd_data    (bus.rd_data)
   );

   assign bus.reg_rdata  = s_q.rdata;
   assign bus.reg_rvalid = s_q.rvalid;
   assign bus.dma_dma_trigger_select   = s_q.dma_trigger_select;
   assign bus.word_busy  = s_q.word_busy;
   assign bus.busy       = s_q.busy;
   assign bus.rd_viol    = s_q.viol;
endmodule

// >>> common/fwc_pkg.sv
package fwc_pkg;
   localparam int CLK_MHZ         = 20;
   localparam int WORD_PROG_NS    = 20000;
   localparam int WORD_PROG_CYC   = (WORD_PROG_NS * CLK_MHZ + 999) / 1000;
   localparam int STALL_NS        = 40000;
   localparam int STALL_CYC       = (STALL_NS * CLK_MHZ) / 1000;
   localparam int PAGE_ERASE_MS   = 20;
   localparam int PAGE_ERASE_CYC  = PAGE_ERASE_MS * CLK_MHZ * 1000;
   localparam int WORD_ADDR_W     = 15;
   localparam int WORD_W          = 32;
   localparam int PAGE_BYTES      = 2048;
   localparam int PAGE_LSB        = 9;
   localparam int PAGE_SEL_LSB    = 1;
   localparam int PAGE_SEL_W      = 6;
   localparam logic [2:0] SEL_CTL     = 3'h0;
   localparam logic [2:0] SEL_ADDR_LO = 3'h1;
   localparam logic [2:0] SEL_ADDR_HI = 3'h2;
   localparam logic [2:0] SEL_TIMING  = 3'h3;
   localparam logic [2:0] SEL_DATA    = 3'h4;
   localparam int CTL_ERASE       = 0;
   localparam int CTL_WRITE       = 1;
   localparam int CTL_WORD_BUSY   = 6;
   localparam int CTL_BUSY        = 7;
   localparam logic [5:0] TIMING_RST   = 6'h2A;
   localparam logic [5:0] TIMING_16MHZ = 6'h15;
   localparam logic [4:0] DMA_DMA_TRIGGER_SELECT_FLASH = 5'h12;
   localparam logic [7:0] OFS_REG_WRITE  = 8'h00;
   localparam logic [7:0] OFS_REG_READ   = 8'h04;
   localparam logic [7:0] OFS_FETCH      = 8'h08;
   localparam logic [7:0] OFS_FETCH_DATA = 8'h0C;
   localparam logic [7:0] OFS_STATUS     = 8'h10;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ERASE,
      ST_COLLECT,
      ST_PROGRAM
   } fwc_state_t;
endpackage

// >>> common/fwc_if.sv
`timescale 1ns/1ps
interface fwc_if;
   logic        reg_wr;
   logic        reg_rd;
   logic [2:0]  reg_sel;
   logic [7:0]  reg_wdata;
   logic [7:0]  reg_rdata;
   logic        reg_rvalid;
   logic        dma_dma_trigger_select;
   logic        word_busy;
   logic        busy;
   logic        rd_req;
   logic [14:0] rd_addr;
   logic        rd_valid;
   logic [31:0] rd_data;
   logic        rd_viol;
   modport dev (
      input  reg_wr,
      input  reg_rd,
      input  reg_sel,
      input  reg_wdata,
      output reg_rdata,
      output reg_rvalid,
      output dma_dma_trigger_select,
      output word_busy,
      output busy,
      input  rd_req,
      input  rd_addr,
      output rd_valid,
      output rd_data,
      output rd_viol
   );
   modport host (
      output reg_wr,
      output reg_rd,
      output reg_sel,
      output reg_wdata,
      input  reg_rdata,
      input  reg_rvalid,
      input  dma_dma_trigger_select,
      input  word_busy,
      input  busy,
      output rd_req,
      output rd_addr,
      input  rd_valid,
      input  rd_data,
      input  rd_viol
   );
endinterface

// >>> verilog/fwc_array.sv
`timescale 1ns/1ps
module fwc_array #(
   parameter int ADDR_W   = fwc_pkg::WORD_ADDR_W,
   parameter int PAGE_LSB = fwc_pkg::PAGE_LSB
) (
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   input  wire logic                         prog_en,
   input  wire logic [ADDR_W-1:0]            prog_addr,
   input  wire logic [31:0]                  prog_data,
   input  wire logic                         erase_en,
   input  wire logic [ADDR_W-PAGE_LSB-1:0]   erase_page,
   input  wire logic                         rd_en,
   input  wire logic [ADDR_W-1:0]            rd_addr,
   output logic                              rd_valid,
   output logic [31:0]                       rd_data
);
   localparam int DEPTH      = 1 << ADDR_W;
   localparam int PAGE_WORDS = 1 << PAGE_LSB;

   // nonvolatile contents: no reset on the array itself
   logic [31:0] mem [DEPTH];

   always_ff @(posedge pclk)
   begin
      if (prog_en)
      begin
         mem[prog_addr] <= mem[prog_addr] & prog_data; // [RULE3] [RULE1]
      end
      if (erase_en)
      begin
         for (int i = 0; i < PAGE_WORDS; i++)
         begin
            mem[{erase_page, PAGE_LSB'(i)}] <= '1; // [RULE4] [RULE1]
         end
      end
      if (rd_en)
      begin
         rd_data <= mem[rd_addr];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rd_valid <= 1'b0;
      end
      else
      begin
         rd_valid <= rd_en;
      end
   end
endmodule

// >>> verilog/fwc_host.sv
`timescale 1ns/1ps
module fwc_host #(
   parameter int PADDR_W = 8
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [PADDR_W-1:0] paddr,
   input  wire logic [31:0]        pwdata,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   fwc_if.host                     bus
);
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic        reg_wr;
      logic        reg_rd;
      logic [2:0]  reg_sel;
      logic [7:0]  reg_wdata;
      logic        rd_req;
      logic [14:0] rd_addr;
      logic        fetch_pend;
      logic        fetch_done;
      logic [31:0] fdata;
      logic [7:0]  rres;
      logic        rres_v;
      logic        dma_trigger_select_seen;
      logic        viol_seen;
   } fwc_host_t;

   fwc_host_t s_q;
   fwc_host_t s_d;
   logic      setup;
   logic      commit;
   logic      known;
   logic [7:0] ofs;

   assign ofs    = 8'(paddr);
   assign setup  = psel && penable && !s_q.pready;
   assign commit = psel && penable && s_q.pready;
   assign known  = (ofs == fwc_pkg::OFS_REG_WRITE) ||
                   (ofs == fwc_pkg::OFS_REG_READ) ||
                   (ofs == fwc_pkg::OFS_FETCH) ||
                   (ofs == fwc_pkg::OFS_FETCH_DATA) ||
                   (ofs == fwc_pkg::OFS_STATUS);

   always_comb
   begin
      s_d        = s_q;
      s_d.reg_wr = 1'b0;
      s_d.reg_rd = 1'b0;
      s_d.rd_req = 1'b0;
      // one wait state: answer is prepared in the first access cycle
      s_d.pready  = setup;
      s_d.pslverr = setup && !known;
      if (setup && !pwrite)
      begin
         case (ofs)
            fwc_pkg::OFS_REG_READ:   s_d.prdata = {23'h0, s_q.rres_v, s_q.rres};
            fwc_pkg::OFS_FETCH:      s_d.prdata = {30'h0, s_q.fetch_done,
                                                   s_q.fetch_pend};
            fwc_pkg::OFS_FETCH_DATA: s_d.prdata = s_q.fdata;
            fwc_pkg::OFS_STATUS:     s_d.prdata = {28'h0, s_q.viol_seen,
                                                   s_q.dma_trigger_select_seen, bus.busy,
                                                   bus.word_busy};
            default:                 s_d.prdata = 32'h0;
         endcase
      end
      if (commit && pwrite)
      begin
         case (ofs)
            fwc_pkg::OFS_REG_WRITE:
            begin
               s_d.reg_wr    = 1'b1; // [RULE6]
               s_d.reg_sel   = pwdata[10:8];
               s_d.reg_wdata = pwdata[7:0];
            end
            fwc_pkg::OFS_REG_READ:
            begin
               s_d.reg_rd  = 1'b1;
               s_d.reg_sel = pwdata[10:8];
               s_d.rres_v  = 1'b0;
            end
            fwc_pkg::OFS_FETCH:
            begin
               s_d.fetch_pend = 1'b1;
               s_d.fetch_done = 1'b0;
               s_d.rd_addr    = pwdata[14:0];
            end
            fwc_pkg::OFS_STATUS:
            begin
               if (pwdata[2])
               begin
                  s_d.dma_trigger_select_seen = 1'b0;
               end
               if (pwdata[3])
               begin
                  s_d.viol_seen = 1'b0;
               end
            end
            default: ;
         endcase
      end
      // fetch waits for the word to finish instead of colliding with it
      if (s_q.fetch_pend && !bus.word_busy && !s_q.rd_req) // [RULE11]
      begin
         s_d.rd_req     = 1'b1;
         s_d.fetch_pend = 1'b0;
      end
      // sets come last so an event beats a same-cycle clear
      if (bus.reg_rvalid)
      begin
         s_d.rres   = bus.reg_rdata;
         s_d.rres_v = 1'b1;
      end
      if (bus.rd_valid)
      begin
         s_d.fdata      = bus.rd_data;
         s_d.fetch_done = 1'b1;
      end
      if (bus.rd_viol)
      begin
         s_d.viol_seen  = 1'b1;
         s_d.fetch_done = 1'b1;
      end
      if (bus.dma_dma_trigger_select)
      begin
         s_d.dma_trigger_select_seen = 1'b1; // [RULE15]
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign prdata        = s_q.prdata;
   assign pready        = s_q.pready;
   assign pslverr       = s_q.pslverr;
   assign bus.reg_wr    = s_q.reg_wr;
   assign bus.reg_rd    = s_q.reg_rd;
   assign bus.reg_sel   = s_q.reg_sel;
   assign bus.reg_wdata = s_q.reg_wdata;
   assign bus.rd_req    = s_q.rd_req;
   assign bus.rd_addr   = s_q.rd_addr;
endmodule

// >>> test/fwc_assertions.sv
`timescale 1ns/1ps
module fwc_assertions #(
   parameter int PROG_CYC  = 10,
   parameter int STALL_CYC = 20
) (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       reg_wr,
   input wire logic [2:0] reg_sel,
   input wire logic [7:0] reg_wdata,
   input wire logic       dma_dma_trigger_select,
   input wire logic       word_busy,
   input wire logic       busy,
   input wire logic       rd_req,
   input wire logic       rd_valid,
   input wire logic       rd_viol
);
   logic [15:0] wb_q;
   logic [15:0] gap_q;
   logic        coll_q;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // gap counts idle cycles of a write sequence, cleared by any progress
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wb_q   <= 16'h0000;
         gap_q  <= 16'h0000;
         coll_q <= 1'b0;
      end
      else
      begin
         wb_q   <= word_busy ? wb_q + 16'h0001 : 16'h0000;
         coll_q <= busy && (coll_q || dma_dma_trigger_select);
         if (dma_dma_trigger_select || word_busy || (reg_wr && reg_sel == 3'h4))
            gap_q <= 16'h0000;
         else
            gap_q <= coll_q ? gap_q + 16'h0001 : 16'h0000;
      end
   end
   property p_start;
      reg_wr && reg_sel == fwc_pkg::SEL_CTL && reg_wdata[1:0] == 2'b10
         && !busy |=> busy && dma_dma_trigger_select;
   endproperty
   a_start: assert property (p_start)
      else $error("write start gave no busy or trigger");
   property p_wb_len; $fell(word_busy) |-> wb_q == PROG_CYC; endproperty
   a_wb_len: assert property (p_wb_len)
      else $error("word busy length wrong");
   property p_commit; $fell(word_busy) |-> dma_dma_trigger_select && busy; endproperty
   a_commit: assert property (p_commit)
      else $error("no trigger after word commit");
   property p_wb_cause;
      $rose(word_busy) |-> $past(reg_wr) && $past(reg_sel) == 3'h4;
   endproperty
   a_wb_cause: assert property (p_wb_cause)
      else $error("word busy without a data byte");
   property p_wb_busy; word_busy |-> busy; endproperty
   a_wb_busy: assert property (p_wb_busy)
      else $error("word busy outside busy");
   property p_rd_one; rd_req |=> rd_valid != rd_viol; endproperty
   a_rd_one: assert property (p_rd_one)
      else $error("fetch answer missing or doubled");
   property p_rd_idle; rd_req && !busy |=> rd_valid; endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("idle fetch refused");
   property p_stall; coll_q && gap_q == STALL_CYC + 4 |-> !busy; endproperty
   a_stall: assert property (p_stall)
      else $error("stalled write not abandoned");
   c_commit: cover property ($fell(word_busy));
   c_stall: cover property (coll_q && gap_q == STALL_CYC);
   c_viol: cover property (rd_req ##1 rd_viol);
endmodule

// >>> test/tb_flash_word_write_controller.sv
`timescale 1ns/1ps
module tb_flash_word_write_controller;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [31:0] rv;
   logic        re;
   int          num_errors;
   int          num_checks;
   fwc_if bus_i ();
   fwc_device #(.ERASE_CYC(50), .PROG_CYC(10), .STALL_CYC(20)) fwc_device_i (
      .pclk(pclk), .presetn(presetn), .bus(bus_i));
   fwc_host fwc_host_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .bus(bus_i));
   fwc_assertions #(.PROG_CYC(10), .STALL_CYC(20)) fwc_assertions_i (
      .pclk(pclk), .presetn(presetn), .reg_wr(bus_i.reg_wr),
      .reg_sel(bus_i.reg_sel), .reg_wdata(bus_i.reg_wdata),
      .dma_dma_trigger_select(bus_i.dma_dma_trigger_select), .word_busy(bus_i.word_busy),
      .busy(bus_i.busy), .rd_req(bus_i.rd_req),
      .rd_valid(bus_i.rd_valid), .rd_viol(bus_i.rd_viol));
   always #25 pclk = ~pclk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask
   // every call starts just after an edge and leaves one idle cycle
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rv = prdata;
      re = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [2:0] s, input logic [7:0] d);
      apb(1'b1, 8'h00, {21'h0, s, d});
   endtask
   task automatic rdreg(input logic [2:0] s);
      apb(1'b1, 8'h04, {21'h0, s, 8'h00});
      rv = 32'h0;
      while (rv[8] !== 1'b1)
         apb(1'b0, 8'h04, 32'h0);
   endtask
   task automatic fetch(input logic [14:0] a);
      apb(1'b1, 8'h08, {17'h0, a});
      rv = 32'h0;
      while (rv[1] !== 1'b1)
         apb(1'b0, 8'h08, 32'h0);
      apb(1'b0, 8'h0C, 32'h0);
   endtask
   task automatic setaddr(input logic [14:0] a);
      wr(3'h2, {1'b0, a[14:8]});
      wr(3'h1, a[7:0]);
   endtask
   task automatic idle();
      rv = 32'h2;
      while (rv[1] !== 1'b0)
         apb(1'b0, 8'h10, 32'h0);
   endtask
   // waits out the programming so the next byte is never refused
   task automatic put(input logic [31:0] w);
      for (int i = 0; i < 4; i++)
         wr(3'h4, w[8*i+:8]);
      while (bus_i.word_busy !== 1'b1)
         @(posedge pclk);
      while (bus_i.word_busy !== 1'b0)
         @(posedge pclk);
   endtask
   task automatic t_timing();
      rdreg(3'h3);
      chk(rv, 32'h12A);
      wr(3'h3, 8'h15);
      rdreg(3'h3);
      chk(rv, 32'h115);
      apb(1'b1, 8'h20, 32'hFFFFFFFF);
      chk({31'h0, re}, 32'h1);
      apb(1'b0, 8'h20, 32'h0);
      chk({re, rv[30:0]}, 32'h80000000);
      $display("t_timing done");
   endtask
   task automatic t_block();
      setaddr(15'h0BFE);
      wr(3'h0, 8'h01);
      idle();
      fetch(15'h0BFF);
      chk(rv, 32'hFFFFFFFF);
      apb(1'b1, 8'h10, 32'hC);
      wr(3'h0, 8'h02);
      apb(1'b0, 8'h10, 32'h0);
      chk(rv & 32'h6, 32'h6);
      put(32'h12345678);
      put(32'hA5C3F00F);
      wr(3'h0, 8'h00);
      apb(1'b0, 8'h10, 32'h0);
      chk(rv & 32'h3, 32'h0);
      fetch(15'h0BFE);
      chk(rv, 32'h12345678);
      fetch(15'h0BFF);
      chk(rv, 32'hA5C3F00F);
      setaddr(15'h0BFE);
      wr(3'h0, 8'h02);
      put(32'hFF00FFFF);
      wr(3'h0, 8'h00);
      fetch(15'h0BFE);
      chk(rv, 32'h12005678);
      $display("t_block done");
   endtask
   task automatic t_stall();
      setaddr(15'h0BFD);
      wr(3'h0, 8'h02);
      wr(3'h4, 8'h99);
      wr(3'h4, 8'h88);
      repeat (30) @(posedge pclk);
      apb(1'b0, 8'h10, 32'h0);
      chk(rv & 32'h2, 32'h0);
      // erase and write together: bytes only count once the trigger shows
      apb(1'b1, 8'h10, 32'hC);
      wr(3'h0, 8'h03);
      rv = 32'h0;
      while (rv[2] !== 1'b1)
         apb(1'b0, 8'h10, 32'h0);
      put(32'h11223344);
      wr(3'h0, 8'h00);
      fetch(15'h0BFD);
      chk(rv, 32'h11223344);
      fetch(15'h0BFE);
      chk(rv, 32'hFFFFFFFF);
      $display("t_stall done");
   endtask
   task automatic t_viol();
      setaddr(15'h0200);
      apb(1'b1, 8'h10, 32'hC);
      wr(3'h0, 8'h01);
      apb(1'b1, 8'h08, 32'h0200);
      idle();
      chk(rv & 32'h8, 32'h8);
      apb(1'b1, 8'h10, 32'hC);
      apb(1'b0, 8'h10, 32'h0);
      chk(rv & 32'h8, 32'h0);
      $display("t_viol done");
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      pclk    = 1'b0;
      presetn = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      num_errors = 0;
      num_checks = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_timing();
      t_block();
      t_stall();
      t_viol();
      summarize();
   end
   // a healthy run needs well under a tenth of this
   initial
   begin
      repeat (30000) @(posedge pclk);
      num_errors++;
      summarize();
   end
endmodule
